/* File: hdl/lsc_pkg.sv */
package lsc_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] LED2_SINK_ADDR   = 8'h19;
   localparam logic [7:0] LED1_SINK_ADDR   = 8'h1A;
   localparam logic [7:0] CMP_CONFIG_ADDR  = 8'h1B;

   // ----------------------------------------
   // field positions and reset values
   // ----------------------------------------
   localparam int          CODE_W          = 7;
   localparam int          SENSOR_FILTER_TIME_LSB        = 5;
   localparam int          SENSOR_FILTER_TIME_W          = 3;
   localparam int          FORCE_BIT       = 4;
   localparam int          L3_RES_BIT      = 3;
   localparam int          L2_RES_BIT      = 2;
   localparam int          LEVEL3_ENABLE_BIT = 1;
   localparam int          LEVEL2_ENABLE_BIT = 0;
   localparam logic [7:0]  SINK_RESET      = 8'h00;
   localparam logic [7:0]  CFG_RESET       = 8'h00;
   localparam logic [7:0]  READ_ZERO       = 8'h00;

   // ----------------------------------------
   // current law, in microamps
   // ----------------------------------------
   localparam logic [6:0]  CODE_FULL       = 7'h7F;
   localparam logic [31:0] FULL_SCALE_UA   = 32'h0000_7530;  // 30 mA
   localparam logic [31:0] LIN_STEP_UA     = 32'h0000_00EC;  // 0.236 mA
   localparam logic [31:0] CODE_FULL_SQ    = 32'h0000_3F01;  // 127 squared

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int          CLK_MHZ         = 250;
   localparam int          SENSOR_FILTER_TIME_BASE_MS    = 80;
   localparam int          SENSOR_FILTER_TIME_BASE_CYC   = SENSOR_FILTER_TIME_BASE_MS * 1000 * CLK_MHZ;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LSC_MODE_DAY    = 2'h0,
      LSC_MODE_OFFICE = 2'h1,
      LSC_MODE_DARK   = 2'h3
   } lsc_mode_t;

   typedef enum logic {
      LSC_CONV_IDLE = 1'b0,
      LSC_CONV_BUSY = 1'b1
   } lsc_conv_t;

   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lsc_reg_req_t;

   typedef struct packed {
      logic level3_below;
      logic level2_below;
      logic conv_done;
   } lsc_sensor_t;

endpackage

/* File: hdl/lsc_sink_law.sv */
`timescale 1ns/1ps
module lsc_sink_law #(
   parameter int CODE_W = lsc_pkg::CODE_W
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              square_law,
   input  wire logic [CODE_W-1:0] code,
   output logic      [31:0]       current_ua_ff
);

   if (CODE_W != lsc_pkg::CODE_W) begin : g_bad_width
      $error("lsc_sink_law: CODE_W must be 7");
   end

   logic [31:0] code_w;
   logic [31:0] nxt_current_ua;

   assign code_w = 32'(code);

   always_comb begin
      if (code == lsc_pkg::CODE_FULL) begin
         nxt_current_ua = lsc_pkg::FULL_SCALE_UA;
      end else if (square_law) begin
         nxt_current_ua = (code_w * code_w * lsc_pkg::FULL_SCALE_UA) / lsc_pkg::CODE_FULL_SQ;
      end else begin
         nxt_current_ua = code_w * lsc_pkg::LIN_STEP_UA;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         current_ua_ff <= 32'h0000_0000;
      end else begin
         current_ua_ff <= nxt_current_ua;
      end
   end

endmodule

/* File: hdl/lsc_regs.sv */
// Notes on behaviour
// - LED2 sink 0x19, LED1 sink 0x1A, 7-bit code
// - zero code none, full code 30 mA
// - filter time 80 ms doubling per code
// - force bit starts one sensor conversion
// - force bit self-clears when results valid
// - force request ignored while backlight on
// - level3 result bit 3, level2 bit 2
// - bit 1 enables level3 comparator
// - bit 0 enables level2 comparator
// - level3 outcome wins over level2 outcome
// - below level2 threshold selects office mode
`timescale 1ns/1ps
module lsc_regs #(
   parameter int SENSOR_FILTER_TIME_BASE_CYC = lsc_pkg::SENSOR_FILTER_TIME_BASE_CYC
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire lsc_pkg::lsc_reg_req_t reg_req,
   output logic [7:0]                rdata_ff,
   input  wire lsc_pkg::lsc_sensor_t sensor_raw,
   input  wire logic                 backlight_on,
   input  wire logic                 square_law,
   output logic [6:0]                led2_current_code_ff,
   output logic [6:0]                led1_current_code_ff,
   output logic [31:0]               led2_current_ua_ff,
   output logic [31:0]               led1_current_ua_ff,
   output logic                      conv_start_ff,
   output lsc_pkg::lsc_mode_t        backlight_mode_ff
);

   if (SENSOR_FILTER_TIME_BASE_CYC < 1) begin : g_bad_sensor_filter_time
      $error("lsc_regs: SENSOR_FILTER_TIME_BASE_CYC must be at least 1");
   end

   // ----------------------------------------
   // configuration state
   // ----------------------------------------
   logic [2:0]         sensor_filter_time_ff;
   logic               force_ff;
   logic               level3_result_ff;
   logic               level2_result_ff;
   logic               level3_enable_ff;
   logic               level2_enable_ff;
   lsc_pkg::lsc_conv_t conv_state_ff;

   logic wr_sink2;
   logic wr_sink1;
   logic wr_cfg;
   assign wr_sink2 = reg_req.wr_en && (reg_req.addr == lsc_pkg::LED2_SINK_ADDR);
   assign wr_sink1 = reg_req.wr_en && (reg_req.addr == lsc_pkg::LED1_SINK_ADDR);
   assign wr_cfg   = reg_req.wr_en && (reg_req.addr == lsc_pkg::CMP_CONFIG_ADDR);

   // ----------------------------------------
   // sensor input synchronisers
   // ----------------------------------------
   lsc_pkg::lsc_sensor_t sens_meta_ff;
   lsc_pkg::lsc_sensor_t sens_sync_ff;
   logic                 done_prev_ff;

   always_ff @(posedge clock) begin
      if (rst) begin
         sens_meta_ff <= '0;
         sens_sync_ff <= '0;
         done_prev_ff <= 1'b0;
      end else begin
         sens_meta_ff <= sensor_raw;
         sens_sync_ff <= sens_meta_ff;
         done_prev_ff <= sens_sync_ff.conv_done;
      end
   end

   logic conv_done_pulse;
   assign conv_done_pulse = sens_sync_ff.conv_done && !done_prev_ff;

   // ----------------------------------------
   // sink current registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         led2_current_code_ff <= lsc_pkg::SINK_RESET[lsc_pkg::CODE_W-1:0];
         led1_current_code_ff <= lsc_pkg::SINK_RESET[lsc_pkg::CODE_W-1:0];
      end else begin
         if (wr_sink2) begin
            led2_current_code_ff <= reg_req.wdata[lsc_pkg::CODE_W-1:0];
         end
         if (wr_sink1) begin
            led1_current_code_ff <= reg_req.wdata[lsc_pkg::CODE_W-1:0];
         end
      end
   end

   logic [6:0] sink_codes [2];
   logic [31:0] sink_ua [2];
   assign sink_codes[0] = led2_current_code_ff;
   assign sink_codes[1] = led1_current_code_ff;
   assign led2_current_ua_ff = sink_ua[0];
   assign led1_current_ua_ff = sink_ua[1];

   for (genvar ch = 0; ch < 2; ch++) begin : g_law
      lsc_sink_law #(
         .CODE_W (lsc_pkg::CODE_W)
      ) u_law (
         .clock         (clock),
         .rst           (rst),
         .square_law    (square_law),
         .code          (sink_codes[ch]),
         .current_ua_ff (sink_ua[ch])
      );
   end

   // ----------------------------------------
   // comparator configuration
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         sensor_filter_time_ff <= lsc_pkg::CFG_RESET[lsc_pkg::SENSOR_FILTER_TIME_LSB +: lsc_pkg::SENSOR_FILTER_TIME_W];
         level3_enable_ff      <= lsc_pkg::CFG_RESET[lsc_pkg::LEVEL3_ENABLE_BIT];
         level2_enable_ff      <= lsc_pkg::CFG_RESET[lsc_pkg::LEVEL2_ENABLE_BIT];
      end else if (wr_cfg) begin
         sensor_filter_time_ff <= reg_req.wdata[lsc_pkg::SENSOR_FILTER_TIME_LSB +: lsc_pkg::SENSOR_FILTER_TIME_W];
         level3_enable_ff      <= reg_req.wdata[lsc_pkg::LEVEL3_ENABLE_BIT];
         level2_enable_ff      <= reg_req.wdata[lsc_pkg::LEVEL2_ENABLE_BIT];
      end
   end

   // ----------------------------------------
   // forced conversion
   // ----------------------------------------
   logic force_set;
   assign force_set = wr_cfg && reg_req.wdata[lsc_pkg::FORCE_BIT] && !backlight_on;

   always_ff @(posedge clock) begin
      if (rst) begin
         force_ff      <= lsc_pkg::CFG_RESET[lsc_pkg::FORCE_BIT];
         conv_state_ff <= lsc_pkg::LSC_CONV_IDLE;
         conv_start_ff <= 1'b0;
      end else begin
         conv_start_ff <= 1'b0;
         unique case (conv_state_ff)
            lsc_pkg::LSC_CONV_IDLE: begin
               if (force_set) begin
                  force_ff      <= 1'b1;
                  conv_start_ff <= 1'b1;
                  conv_state_ff <= lsc_pkg::LSC_CONV_BUSY;
               end
            end
            lsc_pkg::LSC_CONV_BUSY: begin
               if (backlight_on) begin
                  force_ff      <= 1'b0;
                  conv_state_ff <= lsc_pkg::LSC_CONV_IDLE;
               end else if (conv_done_pulse) begin
                  force_ff      <= 1'b0;
                  conv_state_ff <= lsc_pkg::LSC_CONV_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // filtered comparator results
   // ----------------------------------------
   logic [31:0] sensor_filter_time_limit;
   logic        sensor_level [2];
   logic        cmp_en [2];
   logic        cmp_res [2];
   logic        force_load;

   assign sensor_filter_time_limit      = 32'(SENSOR_FILTER_TIME_BASE_CYC) << sensor_filter_time_ff;
   assign force_load      = (conv_state_ff == lsc_pkg::LSC_CONV_BUSY) && conv_done_pulse;
   assign sensor_level[0] = sens_sync_ff.level3_below;
   assign sensor_level[1] = sens_sync_ff.level2_below;
   assign cmp_en[0]  = level3_enable_ff;
   assign cmp_en[1]  = level2_enable_ff;
   assign level3_result_ff = cmp_res[0];
   assign level2_result_ff = cmp_res[1];

   for (genvar c = 0; c < 2; c++) begin : g_cmp
      logic        res_ff;
      logic [31:0] cnt_ff;
      assign cmp_res[c] = res_ff;
      always_ff @(posedge clock) begin
         if (rst) begin
            res_ff <= 1'b0;
            cnt_ff <= 32'h0000_0000;
         end else if (!cmp_en[c]) begin
            res_ff <= 1'b0;
            cnt_ff <= 32'h0000_0000;
         end else if (force_load) begin
            res_ff <= sensor_level[c];
            cnt_ff <= 32'h0000_0000;
         end else if (sensor_level[c] == res_ff) begin
            cnt_ff <= 32'h0000_0000;
         end else if (cnt_ff + 32'h0000_0001 >= sensor_filter_time_limit) begin
            res_ff <= sensor_level[c];
            cnt_ff <= 32'h0000_0000;
         end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------
   // backlight mode selection
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         backlight_mode_ff <= lsc_pkg::LSC_MODE_DAY;
      end else if (level3_enable_ff && level3_result_ff) begin
         backlight_mode_ff <= lsc_pkg::LSC_MODE_DARK;
      end else if (level2_enable_ff && level2_result_ff) begin
         backlight_mode_ff <= lsc_pkg::LSC_MODE_OFFICE;
      end else begin
         backlight_mode_ff <= lsc_pkg::LSC_MODE_DAY;
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_ff <= lsc_pkg::READ_ZERO;
      end else if (reg_req.rd_en) begin
         unique case (reg_req.addr)
            lsc_pkg::LED2_SINK_ADDR:  rdata_ff <= {1'b0, led2_current_code_ff};
            lsc_pkg::LED1_SINK_ADDR:  rdata_ff <= {1'b0, led1_current_code_ff};
            lsc_pkg::CMP_CONFIG_ADDR: rdata_ff <= {sensor_filter_time_ff, force_ff,
                                                   level3_result_ff, level2_result_ff,
                                                   level3_enable_ff, level2_enable_ff};
            default:                  rdata_ff <= lsc_pkg::READ_ZERO;
         endcase
      end
   end

endmodule

/* File: dv/lsc_regs_checker.sv */
`timescale 1ns/1ps
module lsc_regs_checker #(
   parameter int SENSOR_FILTER_TIME_BASE_CYC = 8
) (
   input wire logic                  clock,
   input wire logic                  rst,
   input wire lsc_pkg::lsc_reg_req_t reg_req,
   input wire logic [7:0]            rdata_ff,
   input wire logic                  backlight_on,
   input wire logic                  square_law,
   input wire logic [6:0]            led2_current_code_ff,
   input wire logic [6:0]            led1_current_code_ff,
   input wire logic [31:0]           led2_current_ua_ff,
   input wire logic [31:0]           led1_current_ua_ff,
   input wire logic                  conv_start_ff
);
   logic       wr;
   logic       rd;
   logic [7:0] ad;
   logic [7:0] wd;
   assign wr = reg_req.wr_en;
   assign rd = reg_req.rd_en;
   assign ad = reg_req.addr;
   assign wd = reg_req.wdata;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sink2_write_a: assert property (
      wr && ad == 8'h19 |=> led2_current_code_ff == $past(wd[6:0]))
      else $error("led2 code not written");
   sink1_write_a: assert property (
      wr && ad == 8'h1A |=> led1_current_code_ff == $past(wd[6:0]))
      else $error("led1 code not written");
   sink_read_a: assert property (
      rd && ad == 8'h1A && !wr |=> rdata_ff == {1'b0, $past(led1_current_code_ff)})
      else $error("led1 readback wrong");
   bit7_zero_a: assert property (
      rd && (ad == 8'h19 || ad == 8'h1A) |=> rdata_ff[7] == 1'b0)
      else $error("reserved bit reads one");
   unmapped_read_a: assert property (
      rd && ad > 8'h1B |=> rdata_ff == 8'h00)
      else $error("unmapped read not zero");
   zero_current_a: assert property (
      led1_current_code_ff == 7'h00 |=> led1_current_ua_ff == 32'h0000_0000)
      else $error("zero code gives current");
   full_scale_a: assert property (
      led2_current_code_ff == 7'h7F |=> led2_current_ua_ff == 32'h0000_7530)
      else $error("full code not full scale");
   linear_step_a: assert property (
      !square_law && led1_current_code_ff != 7'h7F
      |=> led1_current_ua_ff == {25'h0, $past(led1_current_code_ff)} * 32'h0000_00EC)
      else $error("linear step wrong");
   force_gate_a: assert property (
      conv_start_ff |-> $past(wr && ad == 8'h1B && wd[4] && !backlight_on))
      else $error("conversion start without accepted request");
   start_pulse_a: assert property (
      conv_start_ff |=> !conv_start_ff)
      else $error("start longer than one cycle");
endmodule

/* File: dv/lsc_sensor_model.sv */
`timescale 1ns/1ps
module lsc_sensor_model #(
   parameter int DLY = 5
) (
   input  wire logic           clock,
   input  wire logic           start,
   input  wire logic           l3,
   input  wire logic           l2,
   output lsc_pkg::lsc_sensor_t sens
);
   int   cnt     = 0;
   logic done_ff = 1'b0;
   // conversion finishes DLY cycles after start; done stays up until the next one
   always @(posedge clock) begin
      if (start) begin
         cnt <= DLY;
         done_ff <= 1'b0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         done_ff <= (cnt == 1);
      end
   end
   assign sens = '{level3_below: l3, level2_below: l2, conv_done: done_ff};
endmodule

/* File: dv/tb_lsc_regs.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_lsc_regs;
   logic                  clock;
   logic                  rst;
   lsc_pkg::lsc_reg_req_t req;
   logic [7:0]            rdata;
   lsc_pkg::lsc_sensor_t  sens;
   logic                  bl_on;
   logic                  sq;
   logic                  l3;
   logic                  l2;
   logic [6:0]            c2;
   logic [6:0]            c1;
   logic [31:0]           ua2;
   logic [31:0]           ua1;
   logic                  start;
   lsc_pkg::lsc_mode_t    mode;
   logic [7:0]            rd;
   int                    errors;
   int                    tests_run;

   lsc_regs #(.SENSOR_FILTER_TIME_BASE_CYC(8)) uut (.clock(clock), .rst(rst), .reg_req(req),
      .rdata_ff(rdata), .sensor_raw(sens), .backlight_on(bl_on), .square_law(sq),
      .led2_current_code_ff(c2), .led1_current_code_ff(c1), .led2_current_ua_ff(ua2),
      .led1_current_ua_ff(ua1), .conv_start_ff(start), .backlight_mode_ff(mode));
   lsc_sensor_model #(.DLY(5)) sensor (.clock(clock), .start(start), .l3(l3), .l2(l2),
      .sens(sens));

   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
      @(negedge clock);
      req.wr_en = 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(negedge clock);
      req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clock);
      req.rd_en = 1'b0;
      rd = rdata;
   endtask
   task automatic give_verdict;
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         rdr(8'h19 + 8'(i));
         `CHK(rd, 8'h00)
      end
   endtask
   task automatic t_sink;
      wr(8'h19, 8'hFF);
      rdr(8'h19);
      `CHK(rd, 8'h7F)
      `CHK(ua2, 32'h0000_7530)
      sq = 1'b1;
      wr(8'h1A, 8'h03);
      rdr(8'h1A);
      `CHK(ua2, 32'h0000_7530)
      `CHK(ua1, 32'h0000_0010)
      sq = 1'b0;
      rdr(8'h1A);
      `CHK(ua1, 32'h0000_02C4)
      wr(8'h19, 8'h80);
      rdr(8'h19);
      `CHK(ua2, 32'h0000_0000)
      wr(8'h1C, 8'h55);
      rdr(8'h1C);
      `CHK(rd, 8'h00)
   endtask
   task automatic t_force;
      int n;
      bl_on = 1'b1;
      wr(8'h1B, 8'h10);
      `CHK(start, 1'b0)
      rdr(8'h1B);
      `CHK(rd[4], 1'b0)
      bl_on = 1'b0;
      l3 = 1'b1;
      l2 = 1'b1;
      wr(8'h1B, 8'h13);
      `CHK(start, 1'b1)
      n = 0;
      do begin
         rdr(8'h1B);
         n++;
      end while (rd[4] && n < 40);
      `CHK(rd, 8'h0F)
      `CHK(mode, lsc_pkg::LSC_MODE_DARK)
   endtask
   task automatic t_sensor_filter_time;
      wr(8'h1B, 8'h01);
      rdr(8'h1B);
      `CHK(rd, 8'h05)
      `CHK(mode, lsc_pkg::LSC_MODE_OFFICE)
      l2 = 1'b0;
      wr(8'h1B, 8'h21);
      repeat (13) @(negedge clock);
      `CHK(mode, lsc_pkg::LSC_MODE_OFFICE)
      repeat (17) @(negedge clock);
      `CHK(mode, lsc_pkg::LSC_MODE_DAY)
      l2 = 1'b1;
      repeat (30) @(negedge clock);
      `CHK(mode, lsc_pkg::LSC_MODE_OFFICE)
      wr(8'h1B, 8'h23);
      repeat (30) @(negedge clock);
      `CHK(mode, lsc_pkg::LSC_MODE_DARK)
   endtask

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      errors = 0;
      tests_run = 0;
      rst = 1'b1;
      req = '0;
      bl_on = 1'b0;
      sq = 1'b0;
      l3 = 1'b0;
      l2 = 1'b0;
      repeat (4) @(negedge clock);
      rst = 1'b0;
      t_reset;
      t_sink;
      t_force;
      t_sensor_filter_time;
      give_verdict;
   end
   initial begin
      #20000;
      errors++;
      give_verdict;
   end
endmodule

bind lsc_regs lsc_regs_checker #(.SENSOR_FILTER_TIME_BASE_CYC(SENSOR_FILTER_TIME_BASE_CYC)) chk (.clock(clock),
   .rst(rst), .reg_req(reg_req), .rdata_ff(rdata_ff), .backlight_on(backlight_on),
   .square_law(square_law), .led2_current_code_ff(led2_current_code_ff),
   .led1_current_code_ff(led1_current_code_ff), .led2_current_ua_ff(led2_current_ua_ff),
   .led1_current_ua_ff(led1_current_ua_ff), .conv_start_ff(conv_start_ff));
